// ==== shared/pmc_pkg.sv ====
package pmc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONFIG_WORD = 12'h000;
  localparam logic [11:0] ADDR_PROG_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_ERASE = 12'h00C;
  localparam logic [31:0] ERASE_KEY = 32'h0000_A55A;

  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int WORD_WIDTH = 14;
  localparam int POS_LOWV_EN = 13;
  localparam int POS_STORE_WP = 11;
  localparam int POS_CFG_WP = 9;
  localparam int POS_BOOT_WP = 8;
  localparam int POS_APP_WP = 7;
  localparam int POS_STORE_EN_N = 4;
  localparam int POS_BOOT_EN_N = 3;
  localparam int POS_SIZE_LO = 0;
  localparam int SIZE_WIDTH = 3;
  localparam logic [13:0] WORD_ERASED = 14'h3FFF;
  localparam logic [13:0] MASK_UNIMPL = 14'h1460;
  localparam logic [13:0] MASK_STICKY = 14'h0B98;
  localparam logic [13:0] MASK_SIZE = 14'h0007;

  // ----------------------------------------------------------------
  // program control / status bits
  // ----------------------------------------------------------------
  localparam int POS_CTRL_LOWV_ACTIVE = 0;
  localparam int POS_CTRL_HV_ACTIVE = 1;
  localparam int POS_ST_REFUSED = 0;
  localparam int POS_ST_ERASED = 1;

  // ----------------------------------------------------------------
  // flash write target regions
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    REGION_APP = 5'b00001,
    REGION_BOOT = 5'b00010,
    REGION_CFG = 5'b00100,
    REGION_STORE = 5'b01000,
    REGION_NONE = 5'b10000
  } pmc_region_type;

  typedef struct packed {
    logic allowApp;
    logic allowBoot;
    logic allowCfg;
    logic allowStore;
  } pmc_allow_type;

  typedef struct packed {
    logic storeEnabled;
    logic bootEnabled;
    logic [2:0] bootSize;
  } pmc_layout_type;

endpackage

// ==== core/pmc_config_word.sv ====
// Notes on behaviour
// - low-voltage enable one: pin acts as reset
// - refuse clearing enable during low-voltage session
// - config write protect gates configuration words
// - boot write protect gates boot block
// - application write protect gates application block
// - storage enable bit is active low
// - boot enable bit is active low
// - boot size used only while boot enabled
// - boot size writable only while boot disabled
// - protections sticky; only bulk erase clears; the code also loads the erased word on reset_n
// - bulk erase sets every bit to one
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module pmc_config_word
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash write check
  input wire logic flashWriteReq,
  input wire pmc_region_type flashRegion,
  output logic flashWriteGrant,
  output logic flashWriteDeny,
  // decoded configuration
  output pmc_allow_type allowState,
  output pmc_layout_type layoutState,
  output logic lowVoltageProgEnable,
  output logic resetPinIsReset,
  // pins
  input wire logic resetPinFunctionEnable,
  input wire logic highVoltageDetect
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] fixWord(input logic [13:0] w);
    fixWord = w | MASK_UNIMPL;
  endfunction

  function automatic pmc_allow_type decodeAllow(input logic [13:0] w);
    pmc_allow_type a;
    a.allowApp = w[POS_APP_WP];
    a.allowCfg = w[POS_CFG_WP];
    a.allowBoot = w[POS_BOOT_WP] | w[POS_BOOT_EN_N];
    a.allowStore = w[POS_STORE_WP] | w[POS_STORE_EN_N];
    decodeAllow = a;
  endfunction

  // permission for one target region
  function automatic logic regionAllowed(input pmc_region_type r, input pmc_allow_type a,
                                         input logic storeOff);
    logic ok;
    ok = 1'b0;
    unique case (r)
      REGION_APP: begin
        ok = a.allowApp;
      end
      REGION_BOOT: begin
        ok = a.allowBoot;
      end
      REGION_CFG: begin
        ok = a.allowCfg;
      end
      REGION_STORE: begin
        // a disabled storage area takes no writes at all
        ok = a.allowStore & ~storeOff;
      end
      default: begin
        // unknown or empty target is always refused
        ok = 1'b0;
      end
    endcase
    regionAllowed = ok;
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [13:0] configWord;
  logic lowvActive;
  logic hvActive;
  logic refusedFlag;
  logic erasedFlag;
  logic hvMeta;
  logic hvSync;
  logic pinMeta;
  logic pinSync;
  logic accessPhase;
  logic wrCfg;
  logic wrCtrl;
  logic wrStatus;
  logic wrErase;
  logic doErase;
  logic refuseLowv;
  logic [13:0] next_configWord;
  logic [31:0] next_prdata;
  logic unmapped;
  logic grantNow;
  pmc_allow_type allowNow;

  assign accessPhase = psel & penable;
  assign wrCfg = accessPhase & pwrite & (paddr == ADDR_CONFIG_WORD);
  assign wrCtrl = accessPhase & pwrite & (paddr == ADDR_PROG_CTRL);
  assign wrStatus = accessPhase & pwrite & (paddr == ADDR_STATUS);
  assign wrErase = accessPhase & pwrite & (paddr == ADDR_ERASE);
  // erase needs the key so a stray write cannot drop protection
  assign doErase = wrErase & (pwdata == ERASE_KEY);
  assign unmapped = (paddr != ADDR_CONFIG_WORD) & (paddr != ADDR_PROG_CTRL) &
                    (paddr != ADDR_STATUS) & (paddr != ADDR_ERASE);
  assign allowNow = decodeAllow(configWord);
  assign grantNow = regionAllowed(flashRegion, allowNow, configWord[POS_STORE_EN_N]);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hvMeta <= 1'b0;
      hvSync <= 1'b0;
    end else begin
      hvMeta <= highVoltageDetect;
      hvSync <= hvMeta;
    end
  end

  // idles high so the pin acts as reset until told otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= resetPinFunctionEnable;
      pinSync <= pinMeta;
    end
  end

  // ----------------------------------------------------------------
  // configuration word write
  // ----------------------------------------------------------------
  always_comb begin
    next_configWord = fixWord(pwdata[13:0]);
    // protections only move toward protected
    next_configWord = (next_configWord & MASK_STICKY & configWord) |
                      (next_configWord & ~MASK_STICKY);
    // enable falls by write only outside a low-voltage session
    next_configWord[POS_LOWV_EN] = configWord[POS_LOWV_EN] & (pwdata[POS_LOWV_EN] | lowvActive);
    if (!configWord[POS_BOOT_EN_N]) begin
      next_configWord[2:0] = configWord[2:0];
    end
  end

  assign refuseLowv = wrCfg & lowvActive & ~pwdata[POS_LOWV_EN] & configWord[POS_LOWV_EN];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      configWord <= WORD_ERASED;
    end else if (doErase) begin
      configWord <= WORD_ERASED;
    end else if (wrCfg) begin
      configWord <= fixWord(next_configWord);
    end
  end

  // ----------------------------------------------------------------
  // programming session control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lowvActive <= 1'b0;
    end else if (wrCtrl) begin
      lowvActive <= pwdata[POS_CTRL_LOWV_ACTIVE] & configWord[POS_LOWV_EN];
    end else if (!configWord[POS_LOWV_EN]) begin
      lowvActive <= 1'b0;
    end
  end

  // high voltage entry counts only with low-voltage entry off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hvActive <= 1'b0;
    end else begin
      hvActive <= hvSync & ~configWord[POS_LOWV_EN];
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refusedFlag <= 1'b0;
    end else if (refuseLowv) begin
      refusedFlag <= 1'b1;
    end else if (wrStatus && pwdata[POS_ST_REFUSED]) begin
      refusedFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      erasedFlag <= 1'b0;
    end else if (doErase) begin
      erasedFlag <= 1'b1;
    end else if (wrStatus && pwdata[POS_ST_ERASED]) begin
      erasedFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CONFIG_WORD: begin
        next_prdata[13:0] = configWord;
      end
      ADDR_PROG_CTRL: begin
        next_prdata[POS_CTRL_LOWV_ACTIVE] = lowvActive;
        next_prdata[POS_CTRL_HV_ACTIVE] = hvActive;
      end
      ADDR_STATUS: begin
        next_prdata[POS_ST_REFUSED] = refusedFlag;
        next_prdata[POS_ST_ERASED] = erasedFlag;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // captured in setup, stands through the access phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= unmapped;
    end
  end

  // zero wait states once out of reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // flash write check
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flashWriteGrant <= 1'b0;
    end else begin
      flashWriteGrant <= flashWriteReq & grantNow;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flashWriteDeny <= 1'b0;
    end else begin
      flashWriteDeny <= flashWriteReq & ~grantNow;
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      allowState <= '1;
    end else begin
      allowState <= allowNow;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      layoutState <= '0;
    end else begin
      layoutState.storeEnabled <= ~configWord[POS_STORE_EN_N];
      layoutState.bootEnabled <= ~configWord[POS_BOOT_EN_N];
      layoutState.bootSize <= configWord[POS_BOOT_EN_N] ? 3'h0 : configWord[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lowVoltageProgEnable <= 1'b1;
    end else begin
      lowVoltageProgEnable <= configWord[POS_LOWV_EN];
    end
  end

  // enable bit overrides the separate pin function setting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resetPinIsReset <= 1'b1;
    end else begin
      resetPinIsReset <= configWord[POS_LOWV_EN] | pinSync;
    end
  end

endmodule

`default_nettype wire

// ==== dv/pmc_config_word_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmc_config_word_assertions
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // flash check and decoded state
  input wire logic flashWriteReq,
  input wire pmc_region_type flashRegion,
  input wire logic flashWriteGrant,
  input wire logic flashWriteDeny,
  input wire pmc_allow_type allowState,
  input wire pmc_layout_type layoutState,
  input wire logic lowVoltageProgEnable,
  input wire logic resetPinIsReset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic eraseHit;
  assign eraseHit = psel && penable && pwrite && paddr == ADDR_ERASE;
  property p_lowvReset; lowVoltageProgEnable |-> resetPinIsReset; endproperty
  a_lowvReset: assert property (p_lowvReset) else $error("pin not reset");
  property p_answer; flashWriteReq |=> flashWriteGrant != flashWriteDeny; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_idle; !flashWriteReq |=> !flashWriteGrant && !flashWriteDeny; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_cfg;
    flashWriteReq && flashRegion == REGION_CFG && $stable(allowState) |=> flashWriteGrant == $past(allowState.allowCfg);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config grant wrong");
  property p_boot;
    flashWriteReq && flashRegion == REGION_BOOT && $stable(allowState) |=> flashWriteGrant == $past(allowState.allowBoot);
  endproperty
  a_boot: assert property (p_boot) else $error("boot grant wrong");
  property p_app;
    flashWriteReq && flashRegion == REGION_APP && $stable(allowState) |=> flashWriteGrant == $past(allowState.allowApp);
  endproperty
  a_app: assert property (p_app) else $error("app grant wrong");
  property p_size; !layoutState.bootEnabled |-> layoutState.bootSize == 3'h0; endproperty
  a_size: assert property (p_size) else $error("size used while off");
  property p_sticky; $rose(allowState.allowCfg) |-> $past(eraseHit, 2); endproperty
  a_sticky: assert property (p_sticky) else $error("protection undone");
  c_deny: cover property (flashWriteReq ##1 flashWriteDeny);
  c_erase: cover property (eraseHit);
  c_boot: cover property (layoutState.bootEnabled);
endmodule
`default_nettype wire

// ==== dv/pmc_programmer_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmc_programmer_model (
  // programmer side
  input wire logic enterReq,
  input wire logic lowVoltageProgEnable,
  output logic highVoltageDetect
);
  // high voltage only when low-voltage entry is off
  assign highVoltageDetect = enterReq && !lowVoltageProgEnable;
endmodule
`default_nettype wire

// ==== dv/program_memory_protection_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module program_memory_protection_config_tb;
  import pmc_pkg::*;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic flashWriteReq = 0, pinFnEn = 0, enterReq = 0, hvDet;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, grant, deny, lowvOut, rstIsRst;
  pmc_region_type flashRegion = REGION_NONE;
  pmc_allow_type allowState;
  pmc_layout_type layoutState;
  logic [13:0] word = WORD_ERASED;
  logic sess = 0;
  int n_fail = 0, checks = 0, cyc = 0;
  always #50 clk_sys = ~clk_sys;
  pmc_config_word pmc_config_word_inst (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashWriteReq(flashWriteReq), .flashRegion(flashRegion), .flashWriteGrant(grant), .flashWriteDeny(deny),
    .allowState(allowState), .layoutState(layoutState), .lowVoltageProgEnable(lowvOut),
    .resetPinIsReset(rstIsRst), .resetPinFunctionEnable(pinFnEn), .highVoltageDetect(hvDet));
  pmc_programmer_model pmc_programmer_model_inst (.enterReq(enterReq), .lowVoltageProgEnable(lowvOut),
    .highVoltageDetect(hvDet));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic flash(input pmc_region_type rg, input logic ok);
    @(posedge clk_sys);
    flashWriteReq <= 1'b1;
    flashRegion <= rg;
    @(posedge clk_sys);
    flashWriteReq <= 1'b0;
    @(negedge clk_sys);
    chk(32'({grant, deny}), 32'({ok, !ok}));
  endtask
  function automatic logic [13:0] nxt(input logic [13:0] o, input logic [13:0] d, input logic s);
    logic [13:0] n;
    n = (o & ~MASK_STICKY) | (o & d & MASK_STICKY);
    n[13] = o[13] & (d[13] | s);
    n[2:0] = o[3] ? d[2:0] : o[2:0];
    return n | MASK_UNIMPL;
  endfunction
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    logic [31:0] d;
    d = $urandom(21177);
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, ADDR_CONFIG_WORD, '0, rd);
    chk(rd, 32'(WORD_ERASED));
    for (int i = 0; i < 40; i++) begin
      if ($urandom_range(2) == 0) begin
        apb(1'b1, ADDR_ERASE, ERASE_KEY, rd);
        word = WORD_ERASED;
      end
      d = $urandom;
      pinFnEn <= d[20];
      apb(1'b1, ADDR_PROG_CTRL, {31'h0, d[16]}, rd);
      if (word[13]) sess = d[16];
      apb(1'b1, ADDR_CONFIG_WORD, d, rd);
      word = nxt(word, d[13:0], sess);
      apb(1'b0, ADDR_CONFIG_WORD, '0, rd);
      chk(rd, 32'(word));
      flash(REGION_CFG, word[9]);
      flash(REGION_BOOT, word[3] | word[8]);
      flash(REGION_APP, word[7]);
      flash(REGION_STORE, !word[4] & word[11]);
      chk(32'(layoutState), 32'({!word[4], !word[3], word[3] ? 3'h0 : word[2:0]}));
      chk(32'(rstIsRst), 32'(word[13] | d[20]));
    end
    apb(1'b1, 12'h010, 32'h0000_FFFF, rd);
    chk(32'(pslverr), 32'h0000_0001);
    apb(1'b1, ADDR_ERASE, ERASE_KEY, rd);
    apb(1'b1, ADDR_PROG_CTRL, 32'h0000_0001, rd);
    apb(1'b1, ADDR_CONFIG_WORD, '0, rd);
    apb(1'b0, ADDR_CONFIG_WORD, '0, rd);
    chk(rd, 32'h0000_3460);
    apb(1'b0, ADDR_STATUS, '0, rd);
    chk(32'(rd[0]), 32'h0000_0001);
    apb(1'b1, ADDR_PROG_CTRL, '0, rd);
    apb(1'b1, ADDR_CONFIG_WORD, '0, rd);
    enterReq <= 1'b1;
    pinFnEn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    apb(1'b0, ADDR_PROG_CTRL, '0, rd);
    chk(32'(rd[1]), 32'h0000_0001);
    chk(32'(rstIsRst), 32'h0000_0000);
    wrap_up;
  end
endmodule
bind pmc_config_word pmc_config_word_assertions pmc_config_word_assertions_inst (.*);
`default_nettype wire
